// ==== bce_branch_compare_execute.sv ====
// execute unit for calls, returns, compares, skips, branches and fractional multiply
`timescale 1ns/1ps
module bce_branch_compare_execute #(
  parameter int PC_W   = bce_pkg::BCE_PC_W,
  parameter int OFS_W  = bce_pkg::BCE_OFS_W,
  parameter int BOFS_W = bce_pkg::BCE_BOFS_W
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              START_I,
  input  wire bce_pkg::bce_op_t  OP_I,
  input  wire logic [PC_W-1:0]   PC_I,
  input  wire logic [7:0]        RD_I,
  input  wire logic [7:0]        RR_I,
  input  wire logic [7:0]        IMM_I,
  input  wire logic [OFS_W-1:0]  OFFSET_I,
  input  wire logic [PC_W-1:0]   TARGET_I,
  input  wire logic [PC_W-1:0]   ZPTR_I,
  input  wire logic [PC_W-1:0]   STACK_PC_I,
  input  wire logic [2:0]        BIT_SEL_I,
  input  wire logic [7:0]        IO_BYTE_I,
  input  wire logic [7:0]        STATUS_REG_I,
  input  wire logic              NEXT_TWO_WORD_I,
  output logic                   BUSY_O,
  output logic                   DONE_O,
  output logic [PC_W-1:0]        PC_O,
  output logic [7:0]             STATUS_REG_O,
  output logic [15:0]            RES_O,
  output logic                   RES_WE_O,
  output logic                   PUSH_O,
  output logic                   POP_O,
  output logic [PC_W-1:0]        RET_ADDR_O,
  output logic [2:0]             CYCLES_O
);

  // whole module state
  typedef struct packed {
    logic            busy;
    logic [2:0]      cnt;
    logic [2:0]      cycles;
    logic [PC_W-1:0] pc;
    logic [7:0]      flg;
    logic [15:0]     res;
    logic            res_we;
    logic            push;
    logic            pop;
    logic [PC_W-1:0] ret_addr;
  } bce_state_t;

  bce_state_t       st_reg;
  bce_state_t       st_next;

  logic             done;
  logic             accept;
  logic [PC_W-1:0]  call_ofs;
  logic [PC_W-1:0]  br_ofs;
  logic [PC_W-1:0]  pc_plus1;
  logic [PC_W-1:0]  pc_skip;
  logic [PC_W-1:0]  pc_call;
  logic [PC_W-1:0]  pc_branch;
  logic [2:0]       skip_cyc;
  logic [7:0]       cmp_b;
  logic             cmp_borrow;
  logic             cmp_chain;
  logic             cmp_z;
  logic             cmp_n;
  logic             cmp_v;
  logic             cmp_c;
  logic             cmp_h;
  logic signed [16:0] prod_full;
  logic [15:0]      prod;
  logic [15:0]      frac_res;

  logic [PC_W-1:0]  dec_pc;
  logic [7:0]       dec_flg;
  logic [15:0]      dec_res;
  logic             dec_res_we;
  logic             dec_push;
  logic             dec_pop;
  logic [PC_W-1:0]  dec_ret;
  logic [2:0]       dec_cyc;
  logic             take;

  // handshake: last cycle of an instruction, and start acceptance
  assign done   = st_reg.busy && (st_reg.cnt == bce_pkg::BCE_CYC_ONE);
  assign accept = START_I && (!st_reg.busy || done);

  // signed displacements widened to pc width
  assign call_ofs = {{(PC_W-OFS_W){OFFSET_I[OFS_W-1]}}, OFFSET_I};
  assign br_ofs   = {{(PC_W-BOFS_W){OFFSET_I[BOFS_W-1]}}, OFFSET_I[BOFS_W-1:0]};

  // candidate program counters
  assign pc_plus1  = PC_I + bce_pkg::BCE_STEP_ONE[PC_W-1:0];
  assign pc_call   = PC_I + call_ofs + bce_pkg::BCE_STEP_ONE[PC_W-1:0];
  assign pc_branch = PC_I + br_ofs + bce_pkg::BCE_STEP_ONE[PC_W-1:0];
  // a skipped two-word instruction costs one more word and one more cycle
  assign pc_skip   = NEXT_TWO_WORD_I ? PC_I + bce_pkg::BCE_STEP_THREE[PC_W-1:0]
                                     : PC_I + bce_pkg::BCE_STEP_TWO[PC_W-1:0];
  assign skip_cyc  = NEXT_TWO_WORD_I ? bce_pkg::BCE_CYC_THREE : bce_pkg::BCE_CYC_TWO;

  // compare operand select: register with carry, or immediate
  assign cmp_b      = (OP_I == bce_pkg::BCE_COMPARE_IMMEDIATE) ? IMM_I : RR_I;
  assign cmp_borrow = (OP_I == bce_pkg::BCE_COMPARE_WITH_BORROW) && STATUS_REG_I[bce_pkg::BCE_FLAG_C];
  assign cmp_chain  = (OP_I == bce_pkg::BCE_COMPARE_WITH_BORROW) ? STATUS_REG_I[bce_pkg::BCE_FLAG_Z] : 1'b1;

  bce_cmp_flags u_cmp (
    .a_i       (RD_I),
    .b_i       (cmp_b),
    .borrow_i  (cmp_borrow),
    .chain_z_i (cmp_chain),
    .z_o       (cmp_z),
    .n_o       (cmp_n),
    .v_o       (cmp_v),
    .c_o       (cmp_c),
    .h_o       (cmp_h)
  );

  // signed multiplicand times unsigned multiplier, then one-bit fractional shift
  assign prod_full = $signed(RD_I) * $signed({1'b0, RR_I});
  assign prod      = prod_full[15:0];
  assign frac_res  = {prod[14:0], 1'b0};

  // per-instruction decode of pc, flags, result and cycle count
  always_comb
  begin
    dec_pc     = pc_plus1;
    dec_flg    = STATUS_REG_I;
    dec_res    = st_reg.res;
    dec_res_we = 1'b0;
    dec_push   = 1'b0;
    dec_pop    = 1'b0;
    dec_ret    = pc_plus1;
    dec_cyc    = bce_pkg::BCE_CYC_ONE;
    take       = 1'b0;
    unique case (OP_I)
      bce_pkg::BCE_FRAC_MUL_SIGNED_UNSIGNED:
      begin
        dec_res                        = frac_res;
        dec_res_we                     = 1'b1;
        dec_flg[bce_pkg::BCE_FLAG_C]   = prod[15];
        dec_flg[bce_pkg::BCE_FLAG_Z]   = (frac_res == 16'h0000);
        dec_cyc                        = bce_pkg::BCE_CYC_TWO;
      end
      bce_pkg::BCE_RELATIVE_SUBROUTINE_CALL:
      begin
        dec_pc   = pc_call;
        dec_push = 1'b1;
        dec_cyc  = bce_pkg::BCE_CYC_THREE;
      end
      bce_pkg::BCE_INDIRECT_SUBROUTINE_CALL:
      begin
        dec_pc   = ZPTR_I;
        dec_push = 1'b1;
        dec_cyc  = bce_pkg::BCE_CYC_THREE;
      end
      bce_pkg::BCE_DIRECT_SUBROUTINE_CALL:
      begin
        dec_pc   = TARGET_I;
        dec_push = 1'b1;
        dec_ret  = PC_I + bce_pkg::BCE_STEP_TWO[PC_W-1:0]; // target word follows the opcode
        dec_cyc  = bce_pkg::BCE_CYC_FOUR;
      end
      bce_pkg::BCE_SUBROUTINE_RETURN:
      begin
        dec_pc  = STACK_PC_I;
        dec_pop = 1'b1;
        dec_cyc = bce_pkg::BCE_CYC_FOUR;
      end
      bce_pkg::BCE_INTERRUPT_RETURN:
      begin
        dec_pc                        = STACK_PC_I;
        dec_pop                       = 1'b1;
        dec_flg[bce_pkg::BCE_FLAG_I]  = 1'b1;
        dec_cyc                       = bce_pkg::BCE_CYC_FOUR;
      end
      bce_pkg::BCE_COMPARE_SKIP_EQUAL:
      begin
        if (RD_I == RR_I)
        begin
          dec_pc  = pc_skip;
          dec_cyc = skip_cyc;
        end
      end
      bce_pkg::BCE_COMPARE_WITH_BORROW,
      bce_pkg::BCE_COMPARE_IMMEDIATE:
      begin
        dec_flg[bce_pkg::BCE_FLAG_Z] = cmp_z;
        dec_flg[bce_pkg::BCE_FLAG_N] = cmp_n;
        dec_flg[bce_pkg::BCE_FLAG_V] = cmp_v;
        dec_flg[bce_pkg::BCE_FLAG_C] = cmp_c;
        dec_flg[bce_pkg::BCE_FLAG_H] = cmp_h;
      end
      bce_pkg::BCE_SKIP_REG_BIT_ONE:
      begin
        if (RR_I[BIT_SEL_I])
        begin
          dec_pc  = pc_skip;
          dec_cyc = skip_cyc;
        end
      end
      bce_pkg::BCE_SKIP_IO_BIT_ZERO:
      begin
        if (!IO_BYTE_I[BIT_SEL_I])
        begin
          dec_pc  = pc_skip;
          dec_cyc = skip_cyc;
        end
      end
      bce_pkg::BCE_BRANCH_STATUS_BIT_ONE:
        take = STATUS_REG_I[BIT_SEL_I];
      bce_pkg::BCE_BRANCH_UNEQUAL:
        take = !STATUS_REG_I[bce_pkg::BCE_FLAG_Z];
      bce_pkg::BCE_BRANCH_SIGNED_AT_LEAST:
        take = !(STATUS_REG_I[bce_pkg::BCE_FLAG_N] ^ STATUS_REG_I[bce_pkg::BCE_FLAG_V]);
      bce_pkg::BCE_BRANCH_NO_CARRY:
        take = !STATUS_REG_I[bce_pkg::BCE_FLAG_C];
      bce_pkg::BCE_INDIRECT_JUMP:
      begin
        dec_pc  = ZPTR_I;
        dec_cyc = bce_pkg::BCE_CYC_TWO;
      end
    endcase
    // conditional branches share the taken path: one extra cycle
    if (take)
    begin
      dec_pc  = pc_branch;
      dec_cyc = bce_pkg::BCE_CYC_TWO;
    end
  end

  // next state: count down the busy instruction, load a new one on accept
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.busy)
    begin
      st_next.cnt = st_reg.cnt - bce_pkg::BCE_CYC_ONE;
      if (done)
        st_next.busy = 1'b0;
    end
    if (accept)
    begin
      st_next.busy     = 1'b1;
      st_next.cnt      = dec_cyc;
      st_next.cycles   = dec_cyc;
      st_next.pc       = dec_pc;
      st_next.flg      = dec_flg;
      st_next.res      = dec_res;
      st_next.res_we   = dec_res_we;
      st_next.push     = dec_push;
      st_next.pop      = dec_pop;
      st_next.ret_addr = dec_ret;
    end
  end

  // state register, synchronous active-low reset
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      st_reg          <= '0;
      st_reg.pc       <= bce_pkg::BCE_PC_RST[PC_W-1:0];
      st_reg.flg      <= bce_pkg::BCE_FLG_RST;
    end
    else
      st_reg <= st_next;
  end

  // outputs
  assign BUSY_O       = st_reg.busy;
  assign DONE_O       = done;
  assign PC_O         = st_reg.pc;
  assign STATUS_REG_O = st_reg.flg;
  assign RES_O        = st_reg.res;
  assign CYCLES_O     = st_reg.cycles;
  assign RET_ADDR_O   = st_reg.ret_addr;
  assign RES_WE_O     = done && st_reg.res_we;
  assign PUSH_O       = done && st_reg.push;
  assign POP_O        = done && st_reg.pop;

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // finish exactly n cycles after the start edge
  sequence s_done_after2;
    !DONE_O ##1 DONE_O;
  endsequence
  sequence s_done_after3;
    !DONE_O ##1 !DONE_O ##1 DONE_O;
  endsequence
  sequence s_done_after4;
    !DONE_O ##1 !DONE_O ##1 !DONE_O ##1 DONE_O;
  endsequence

  frac_mul_result_a: assert property (accept && OP_I == bce_pkg::BCE_FRAC_MUL_SIGNED_UNSIGNED
    |=> RES_O == $past(frac_res) && STATUS_REG_O[0] == $past(prod[15]) ##0 s_done_after2)
    else $error("fractional multiply result or timing wrong");

  rel_call_pc_a: assert property (accept && OP_I == bce_pkg::BCE_RELATIVE_SUBROUTINE_CALL
    |=> PC_O == $past(PC_I) + $past(call_ofs) + 1'b1 && STATUS_REG_O == $past(STATUS_REG_I)
    ##0 s_done_after3)
    else $error("relative call pc or timing wrong");

  ind_call_pc_a: assert property (accept && OP_I == bce_pkg::BCE_INDIRECT_SUBROUTINE_CALL
    |=> PC_O == $past(ZPTR_I) ##0 s_done_after3)
    else $error("indirect call pc or timing wrong");

  dir_call_pc_a: assert property (accept && OP_I == bce_pkg::BCE_DIRECT_SUBROUTINE_CALL
    |=> PC_O == $past(TARGET_I) ##0 s_done_after4 ##0 PUSH_O)
    else $error("direct call pc or timing wrong");

  sub_return_a: assert property (accept && OP_I == bce_pkg::BCE_SUBROUTINE_RETURN
    |=> PC_O == $past(STACK_PC_I) && STATUS_REG_O == $past(STATUS_REG_I) ##0 s_done_after4)
    else $error("subroutine return wrong");

  int_return_a: assert property (accept && OP_I == bce_pkg::BCE_INTERRUPT_RETURN
    |=> STATUS_REG_O[7] && PC_O == $past(STACK_PC_I) ##0 s_done_after4 ##0 POP_O)
    else $error("interrupt return wrong");

  cmp_skip_a: assert property (accept && OP_I == bce_pkg::BCE_COMPARE_SKIP_EQUAL && RD_I != RR_I
    |=> DONE_O && PC_O == $past(PC_I) + 1'b1)
    else $error("compare skip taken on unequal operands");

  cmp_borrow_a: assert property (accept && OP_I == bce_pkg::BCE_COMPARE_WITH_BORROW
    |=> DONE_O && STATUS_REG_O[1] == ($past(RD_I) == $past(RR_I) + $past(STATUS_REG_I[0])
        && $past(STATUS_REG_I[1])))
    else $error("compare with borrow zero flag wrong");

  cmp_imm_a: assert property (accept && OP_I == bce_pkg::BCE_COMPARE_IMMEDIATE
    |=> DONE_O && STATUS_REG_O[0] == ($past(RD_I) < $past(IMM_I)))
    else $error("compare immediate carry wrong");

  skip_bit_a: assert property (accept && OP_I == bce_pkg::BCE_SKIP_REG_BIT_ONE && RR_I[BIT_SEL_I]
    && NEXT_TWO_WORD_I |=> PC_O == $past(PC_I) + 2'h3 ##0 s_done_after3)
    else $error("register bit skip wrong");

  skip_io_a: assert property (accept && OP_I == bce_pkg::BCE_SKIP_IO_BIT_ZERO && !IO_BYTE_I[BIT_SEL_I]
    && !NEXT_TWO_WORD_I |=> PC_O == $past(PC_I) + 2'h2 ##0 s_done_after2)
    else $error("io bit skip wrong");

  br_status_a: assert property (accept && OP_I == bce_pkg::BCE_BRANCH_STATUS_BIT_ONE
    && !STATUS_REG_I[BIT_SEL_I] |=> DONE_O && PC_O == $past(PC_I) + 1'b1)
    else $error("status bit branch taken while bit clear");

  br_unequal_a: assert property (accept && OP_I == bce_pkg::BCE_BRANCH_UNEQUAL && !STATUS_REG_I[1]
    |=> PC_O == $past(PC_I) + PC_W'($signed($past(OFFSET_I[BOFS_W-1:0]))) + 1'b1 ##0 s_done_after2)
    else $error("branch unequal not taken");

  br_signed_a: assert property (accept && OP_I == bce_pkg::BCE_BRANCH_SIGNED_AT_LEAST
    && (STATUS_REG_I[2] ^ STATUS_REG_I[3]) |=> DONE_O && PC_O == $past(PC_I) + 1'b1)
    else $error("signed branch taken on negative result");

  br_carry_a: assert property (accept && OP_I == bce_pkg::BCE_BRANCH_NO_CARRY && !STATUS_REG_I[0]
    |=> PC_O == $past(PC_I) + $past(br_ofs) + 1'b1 ##0 s_done_after2)
    else $error("no-carry branch wrong");

  ind_jump_a: assert property (accept && OP_I == bce_pkg::BCE_INDIRECT_JUMP
    |=> PC_O == $past(ZPTR_I) && !PUSH_O ##0 s_done_after2)
    else $error("indirect jump wrong");

endmodule

// ==== bce_pkg.sv ====
// constants, opcodes and flag layout for the branch and compare execute block
// Operation
// - signed-by-unsigned fractional multiply: product shifted left one into r1:r0, Z and C, 2 cycles
// - relative call loads pc plus offset plus one, flags kept, 3 cycles
// - indirect call loads pc from the pointer pair, flags kept, 3 cycles
// - direct call loads pc with the absolute target, flags kept, 4 cycles
// - subroutine return restores pc from stack, flags kept, 4 cycles
// - interrupt return restores pc from stack, sets global interrupt enable, 4 cycles
// - compare and skip advances pc by 2 or 3 when equal, 1/2/3 cycles
// - compare with borrow subtracts register and carry, sets Z N V C H, 1 cycle
// - compare immediate subtracts constant, sets Z N V C H, 1 cycle
// - skip on register bit one advances pc by 2 or 3, 1/2/3 cycles
// - skip on io bit zero advances pc by 2 or 3, 1/2/3 cycles
// - branch on status bit one loads pc plus offset plus one, 1/2 cycles
// - branch unequal taken only while Z is clear, 1 or 2 cycles
// - signed at-least branch taken when N xor V is zero, 1/2 cycles
// - branch no carry taken only when C is zero, 1/2 cycles
// - indirect jump loads pc from the pointer pair, flags kept, 2 cycles
package bce_pkg;

  // widths
  localparam int BCE_PC_W   = 16;
  localparam int BCE_OFS_W  = 12; // relative call displacement
  localparam int BCE_BOFS_W = 7;  // conditional branch displacement

  // status register bit positions
  localparam int BCE_FLAG_I = 7;
  localparam int BCE_FLAG_H = 5;
  localparam int BCE_FLAG_V = 3;
  localparam int BCE_FLAG_N = 2;
  localparam int BCE_FLAG_Z = 1;
  localparam int BCE_FLAG_C = 0;

  // reset values
  localparam logic [7:0]  BCE_FLG_RST  = 8'h00;
  localparam logic [15:0] BCE_PC_RST   = 16'h0000;

  // cycle counts
  localparam logic [2:0] BCE_CYC_ONE   = 3'h1;
  localparam logic [2:0] BCE_CYC_TWO   = 3'h2;
  localparam logic [2:0] BCE_CYC_THREE = 3'h3;
  localparam logic [2:0] BCE_CYC_FOUR  = 3'h4;

  // pc step sizes
  localparam logic [15:0] BCE_STEP_ONE   = 16'h0001;
  localparam logic [15:0] BCE_STEP_TWO   = 16'h0002;
  localparam logic [15:0] BCE_STEP_THREE = 16'h0003;

  // instructions executed by this block
  typedef enum logic [3:0] {
    BCE_FRAC_MUL_SIGNED_UNSIGNED,
    BCE_RELATIVE_SUBROUTINE_CALL,
    BCE_INDIRECT_SUBROUTINE_CALL,
    BCE_DIRECT_SUBROUTINE_CALL,
    BCE_SUBROUTINE_RETURN,
    BCE_INTERRUPT_RETURN,
    BCE_COMPARE_SKIP_EQUAL,
    BCE_COMPARE_WITH_BORROW,
    BCE_COMPARE_IMMEDIATE,
    BCE_SKIP_REG_BIT_ONE,
    BCE_SKIP_IO_BIT_ZERO,
    BCE_BRANCH_STATUS_BIT_ONE,
    BCE_BRANCH_UNEQUAL,
    BCE_BRANCH_SIGNED_AT_LEAST,
    BCE_BRANCH_NO_CARRY,
    BCE_INDIRECT_JUMP
  } bce_op_t;

endpackage

// ==== bce_cmp_flags.sv ====
// subtract-without-store flag unit for the compare instructions
`timescale 1ns/1ps
module bce_cmp_flags (
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       borrow_i,
  input  wire logic       chain_z_i,
  output logic            z_o,
  output logic            n_o,
  output logic            v_o,
  output logic            c_o,
  output logic            h_o
);

  logic [7:0] diff;

  // difference is only used for flags, never stored
  assign diff = a_i - b_i - {7'h00, borrow_i};

  // borrow out of bit 3 and bit 7, signed overflow, sign
  assign h_o = (~a_i[3] & b_i[3]) | (b_i[3] & diff[3]) | (diff[3] & ~a_i[3]);
  assign c_o = (~a_i[7] & b_i[7]) | (b_i[7] & diff[7]) | (diff[7] & ~a_i[7]);
  assign v_o = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
  assign n_o = diff[7];
  // chained zero lets multi-byte compares keep a clear Z
  assign z_o = (diff == 8'h00) & chain_z_i;

endmodule

// ==== bce_branch_compare_execute_tb_top.sv ====
// self-checking testbench for the branch and compare execute block
`timescale 1ns/1ps
module bce_branch_compare_execute_tb_top;
  logic             clk;
  logic             rst_n;
  logic             start;
  bce_pkg::bce_op_t op;
  logic [15:0]      pc_in;
  logic [7:0]       rd;
  logic [7:0]       rr;
  logic [7:0]       imm;
  logic [11:0]      ofs;
  logic [15:0]      target;
  logic [15:0]      zptr;
  logic [15:0]      stack_pc;
  logic [2:0]       bit_sel;
  logic [7:0]       io;
  logic [7:0]       flg;
  logic             two;
  logic             busy;
  logic             done;
  logic [15:0]      pc_out;
  logic [7:0]       flg_out;
  logic [15:0]      res;
  logic             res_we;
  logic             push;
  logic             pop;
  logic [15:0]      ret_addr;
  logic [2:0]       cycles;
  int               mismatches;
  int               comparisons;

  bce_branch_compare_execute i_bce_branch_compare_execute (
    .SYS_CLK_I       (clk),
    .RST_N_I         (rst_n),
    .START_I         (start),
    .OP_I            (op),
    .PC_I            (pc_in),
    .RD_I            (rd),
    .RR_I            (rr),
    .IMM_I           (imm),
    .OFFSET_I        (ofs),
    .TARGET_I        (target),
    .ZPTR_I          (zptr),
    .STACK_PC_I      (stack_pc),
    .BIT_SEL_I       (bit_sel),
    .IO_BYTE_I       (io),
    .STATUS_REG_I    (flg),
    .NEXT_TWO_WORD_I (two),
    .BUSY_O          (busy),
    .DONE_O          (done),
    .PC_O            (pc_out),
    .STATUS_REG_O    (flg_out),
    .RES_O           (res),
    .RES_WE_O        (res_we),
    .PUSH_O          (push),
    .POP_O           (pop),
    .RET_ADDR_O      (ret_addr),
    .CYCLES_O        (cycles)
  );

  // free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // print counts and verdict, then stop
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // compare one value and count it
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // wait for the done pulse, counting cycles after the taking edge
  task automatic wait_done(inout int n);
    while (done !== 1'b1)
    begin
      if (n >= 8)
      begin
        mismatches++;
        $display("Error done expected 1 seen %b", done);
        finish_test();
      end
      @(posedge clk);
      #1 n++;
    end
  endtask

  // issue one instruction and judge the done cycle
  task automatic run(input bce_pkg::bce_op_t o, input logic [2:0] cyc, input logic chk_pc,
                     input logic [15:0] exp_pc, input logic [7:0] exp_sr, input logic [2:0] strb);
    int n;
    op = o;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 1;
    wait_done(n);
    chk("cycle count", 16'(cyc), 16'(n));
    chk("cycles_o", 16'(cyc), 16'(cycles));
    chk("flags", 16'(exp_sr), 16'(flg_out));
    chk("strobes", 16'(strb), 16'({res_we, push, pop}));
    if (chk_pc)
      chk("pc", exp_pc, pc_out);
  endtask

  // branch with the 7-bit signed offset
  task automatic brun(input bce_pkg::bce_op_t o, input logic taken);
    logic [15:0] tgt;
    tgt = pc_in + {{9{ofs[6]}}, ofs[6:0]} + 16'h0001;
    run(o, taken ? 3'h2 : 3'h1, 1'b1, taken ? tgt : pc_in + 16'h0001, flg, 3'h0);
  endtask

  // expected flags of a subtract without store
  function automatic logic [7:0] cmp_flags(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b,
                                           input logic c, input logic zc);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] f;
    d = {1'b0, a} - {1'b0, b} - {8'h00, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    f = s;
    f[5] = h[4];
    f[3] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
    f[2] = d[7];
    f[1] = (d[7:0] == 8'h00) & zc;
    f[0] = d[8];
    return f;
  endfunction

  // outputs after reset
  task automatic test_reset;
    chk("pc", 16'h0000, pc_out);
    chk("flags", 16'h0000, 16'(flg_out));
    chk("busy done", 16'h0000, 16'({busy, done}));
    chk("cycles_o", 16'h0000, 16'(cycles));
    $display("test reset done");
  endtask

  // calls, returns and indirect jump back to back
  task automatic test_calls;
    flg = 8'h5A;
    ofs = 12'hFFE;
    run(bce_pkg::BCE_RELATIVE_SUBROUTINE_CALL, 3'h3, 1'b1, 16'h00FF, flg, 3'h2);
    chk("ret_addr", pc_in + 16'h0001, ret_addr);
    run(bce_pkg::BCE_INDIRECT_SUBROUTINE_CALL, 3'h3, 1'b1, zptr, flg, 3'h2);
    run(bce_pkg::BCE_DIRECT_SUBROUTINE_CALL, 3'h4, 1'b1, target, flg, 3'h2);
    chk("ret_addr", pc_in + 16'h0002, ret_addr);
    run(bce_pkg::BCE_SUBROUTINE_RETURN, 3'h4, 1'b1, stack_pc, flg, 3'h1);
    run(bce_pkg::BCE_INTERRUPT_RETURN, 3'h4, 1'b1, stack_pc, flg | 8'h80, 3'h1);
    run(bce_pkg::BCE_INDIRECT_JUMP, 3'h2, 1'b1, zptr, flg, 3'h0);
    $display("test calls done");
  endtask

  // fractional multiply, nonzero and zero result
  task automatic test_mul;
    logic [15:0] p;
    logic [7:0]  s;
    flg = 8'h43;
    rr = 8'h80;
    for (int k = 0; k < 2; k++)
    begin
      rd = (k == 0) ? 8'hC0 : 8'h00;
      p = {{8{rd[7]}}, rd} * {8'h00, rr};
      s = {flg[7:2], (p[14:0] == 15'h0000), p[15]};
      run(bce_pkg::BCE_FRAC_MUL_SIGNED_UNSIGNED, 3'h2, 1'b0, 16'h0000, s, 3'h4);
      chk("product", {p[14:0], 1'b0}, res);
    end
    $display("test multiply done");
  endtask

  // skips: not taken, over one word, over two words
  task automatic test_skips;
    flg = 8'h00;
    bit_sel = 3'h4;
    for (int k = 0; k < 3; k++)
    begin
      two = (k != 1);
      rd = 8'h3C;
      rr = (k == 0) ? 8'h3D : 8'h3C;
      run(bce_pkg::BCE_COMPARE_SKIP_EQUAL, 3'(k + 1), 1'b1, pc_in + 16'(k + 1), flg, 3'h0);
      rd = (k == 0) ? 8'hEF : 8'h10;
      rr = rd;
      run(bce_pkg::BCE_SKIP_REG_BIT_ONE, 3'(k + 1), 1'b1, pc_in + 16'(k + 1), flg, 3'h0);
      io = (k == 0) ? 8'h10 : 8'hEF;
      run(bce_pkg::BCE_SKIP_IO_BIT_ZERO, 3'(k + 1), 1'b1, pc_in + 16'(k + 1), flg, 3'h0);
    end
    $display("test skips done");
  endtask

  // conditional branches over every condition value
  task automatic test_branches;
    ofs = 12'h040;
    flg = 8'hA5;
    for (int b = 0; b < 8; b++)
    begin
      bit_sel = 3'(b);
      brun(bce_pkg::BCE_BRANCH_STATUS_BIT_ONE, flg[b]);
    end
    for (int z = 0; z < 2; z++)
    begin
      flg = (z == 1) ? 8'h02 : 8'hFD;
      brun(bce_pkg::BCE_BRANCH_UNEQUAL, z == 0);
      flg = (z == 1) ? 8'h01 : 8'hFE;
      brun(bce_pkg::BCE_BRANCH_NO_CARRY, z == 0);
    end
    for (int nv = 0; nv < 4; nv++)
    begin
      flg = 8'(nv << 2);
      brun(bce_pkg::BCE_BRANCH_SIGNED_AT_LEAST, nv == 0 || nv == 3);
    end
    $display("test branches done");
  endtask

  // compares: chained zero, carry in, overflow and half borrow
  task automatic test_compares;
    rd = 8'h11;
    rr = 8'h10;
    flg = 8'h03;
    run(bce_pkg::BCE_COMPARE_WITH_BORROW, 3'h1, 1'b0, 16'h0000, cmp_flags(flg, rd, rr, 1'b1, 1'b1), 3'h0);
    flg = 8'h01;
    run(bce_pkg::BCE_COMPARE_WITH_BORROW, 3'h1, 1'b0, 16'h0000, cmp_flags(flg, rd, rr, 1'b1, 1'b0), 3'h0);
    rd = 8'h80;
    imm = 8'h01;
    flg = 8'h03;
    run(bce_pkg::BCE_COMPARE_IMMEDIATE, 3'h1, 1'b0, 16'h0000, cmp_flags(flg, rd, imm, 1'b0, 1'b1), 3'h0);
    $display("test compares done");
  endtask

  // a start while busy is ignored
  task automatic test_refused;
    int n;
    flg = 8'h00;
    op = bce_pkg::BCE_DIRECT_SUBROUTINE_CALL;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    @(posedge clk);
    #1 op = bce_pkg::BCE_INDIRECT_JUMP;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 3;
    wait_done(n);
    chk("cycle count", 16'h0004, 16'(n));
    chk("pc", target, pc_out);
    @(posedge clk);
    #1 chk("busy", 16'h0000, 16'(busy));
    $display("test refused done");
  endtask

  // main sequence
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    start = 1'b0;
    op = bce_pkg::BCE_INDIRECT_JUMP;
    pc_in = 16'h0100;
    rd = 8'h00;
    rr = 8'h00;
    imm = 8'h00;
    ofs = 12'h000;
    target = 16'hABCD;
    zptr = 16'h1234;
    stack_pc = 16'h4321;
    bit_sel = 3'h0;
    io = 8'h00;
    flg = 8'h00;
    two = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    test_reset();
    test_calls();
    test_mul();
    test_skips();
    test_branches();
    test_compares();
    @(posedge clk);
    #1 test_refused();
    finish_test();
  end
endmodule
